// *** rtl/dmhm_pkg.sv ***
// constants and types for the dual mode hard multiplier
package dmhm_pkg;
  localparam int DMHM_OP_W = 18;
  localparam int DMHM_SEC_W = 9;
  localparam int DMHM_RES_W = 36;
  localparam int DMHM_HALF_W = 18;
  localparam int DMHM_NSEC = 2;

  // static configuration seen from the fabric
  typedef struct packed {
    logic dual;                    // 1: two 9x9, 0: one 18x18
    logic [DMHM_NSEC-1:0] reg_a;   // per-section operand A register select
    logic [DMHM_NSEC-1:0] reg_b;   // per-section operand B register select
    logic reg_sign;                // register the sign selects
    logic [DMHM_NSEC-1:0] reg_out; // per-section result register select
  } dmhm_cfg_t;

  typedef struct packed {
    logic [DMHM_OP_W-1:0] a;
    logic [DMHM_OP_W-1:0] b;
    logic sign_a;
    logic sign_b;
    logic [DMHM_RES_W-1:0] prod;
    logic [DMHM_RES_W-1:0] res;
  } dmhm_state_t;

  localparam dmhm_state_t DMHM_STATE_RST = '0;
endpackage

// *** rtl/dmhm_mult.sv ***
// dual mode hard multiplier: 18x18 or two 9x9, optional pipeline registers
`timescale 1ns/1ps
`default_nettype none
module dmhm_mult (
  input wire logic i_clk,                          // 40 MHz clock
  input wire logic i_resetn,                       // async system reset, low
  input wire logic i_ce,                           // shared clock enable
  input wire logic i_aclr,                         // shared async clear, high
  input wire dmhm_pkg::dmhm_cfg_t i_cfg,           // mode and register selects
  input wire logic [dmhm_pkg::DMHM_OP_W-1:0] i_a,  // operand A (dual: {a1,a0})
  input wire logic [dmhm_pkg::DMHM_OP_W-1:0] i_b,  // operand B (dual: {b1,b0})
  input wire logic i_sign_a,                       // A signed when high
  input wire logic i_sign_b,                       // B signed when high
  output logic [dmhm_pkg::DMHM_RES_W-1:0] o_result // product
);
  import dmhm_pkg::*;

  logic [1:0] rst_sync_reg;
  logic clr_n;
  dmhm_state_t st_reg;
  dmhm_state_t st_next;
  logic [DMHM_OP_W-1:0] op_a;
  logic [DMHM_OP_W-1:0] op_b;
  logic sa;
  logic sb;
  logic [DMHM_RES_W-1:0] prod;

  // sign bit extension makes one signed multiply cover all four sign mixes
  function automatic logic [DMHM_RES_W-1:0] mul18(
    input logic [DMHM_OP_W-1:0] a,
    input logic [DMHM_OP_W-1:0] b,
    input logic sga,
    input logic sgb
  );
    logic signed [DMHM_OP_W:0] ea;
    logic signed [DMHM_OP_W:0] eb;
    logic signed [2*DMHM_OP_W+1:0] p;
    ea = {sga & a[DMHM_OP_W-1], a};
    eb = {sgb & b[DMHM_OP_W-1], b};
    p = ea * eb;
    return p[DMHM_RES_W-1:0];
  endfunction

  function automatic logic [DMHM_HALF_W-1:0] mul9(
    input logic [DMHM_SEC_W-1:0] a,
    input logic [DMHM_SEC_W-1:0] b,
    input logic sga,
    input logic sgb
  );
    logic signed [DMHM_SEC_W:0] ea;
    logic signed [DMHM_SEC_W:0] eb;
    logic signed [2*DMHM_SEC_W+1:0] p;
    ea = {sga & a[DMHM_SEC_W-1], a};
    eb = {sgb & b[DMHM_SEC_W-1], b};
    p = ea * eb;
    return p[DMHM_HALF_W-1:0];
  endfunction

  // picks register or bypass per section; wide mode uses select bit 0 only
  function automatic logic [DMHM_OP_W-1:0] pick_op(
    input logic [DMHM_OP_W-1:0] regd,
    input logic [DMHM_OP_W-1:0] direct,
    input logic [DMHM_NSEC-1:0] sel,
    input logic dual
  );
    logic hi;
    hi = dual ? sel[1] : sel[0];
    return {hi ? regd[DMHM_OP_W-1:DMHM_SEC_W]
               : direct[DMHM_OP_W-1:DMHM_SEC_W],
            sel[0] ? regd[DMHM_SEC_W-1:0] : direct[DMHM_SEC_W-1:0]};
  endfunction

  // async clear reaches every st_reg register; system reset released synchronously
  assign clr_n = rst_sync_reg[1] & ~i_aclr;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  always_comb begin
    op_a = pick_op(st_reg.a, i_a, i_cfg.reg_a, i_cfg.dual);
    op_b = pick_op(st_reg.b, i_b, i_cfg.reg_b, i_cfg.dual);
    sa = i_cfg.reg_sign ? st_reg.sign_a : i_sign_a;
    sb = i_cfg.reg_sign ? st_reg.sign_b : i_sign_b;
    if (i_cfg.dual) begin
      // one sa/sb pair serves both halves
      prod = {mul9(op_a[DMHM_OP_W-1:DMHM_SEC_W], op_b[DMHM_OP_W-1:DMHM_SEC_W],
                   sa, sb),
              mul9(op_a[DMHM_SEC_W-1:0], op_b[DMHM_SEC_W-1:0],
                   sa, sb)};
    end else begin
      prod = mul18(op_a, op_b, sa, sb);
    end
  end

  always_comb begin
    st_next = st_reg;
    if (i_ce) begin
      st_next.a = i_a;
      st_next.b = i_b;
      st_next.sign_a = i_sign_a;
      st_next.sign_b = i_sign_b;
      st_next.prod = prod;
    end
    // the port flop always runs so outputs come from a flip-flop;
    // a bypassed section therefore still shows one cycle of latency
    st_next.res = {(i_cfg.dual ? i_cfg.reg_out[1] : i_cfg.reg_out[0])
                     ? st_reg.prod[DMHM_RES_W-1:DMHM_HALF_W]
                     : prod[DMHM_RES_W-1:DMHM_HALF_W],
                   i_cfg.reg_out[0] ? st_reg.prod[DMHM_HALF_W-1:0]
                                    : prod[DMHM_HALF_W-1:0]};
  end

  always_ff @(posedge i_clk or negedge clr_n) begin
    if (!clr_n) begin
      st_reg <= DMHM_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_result = st_reg.res;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!clr_n);

  AST_CE_HOLD: assert property (
    !i_ce |=> $stable(st_reg.a) && $stable(st_reg.b) && $stable(st_reg.prod)
      && $stable(st_reg.sign_a) && $stable(st_reg.sign_b))
    else $error("registers changed with clock enable low");

  // clear is a level, so every edge it covers must already see zeros
  AST_ACLR_ZERO: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_aclr |-> st_reg == DMHM_STATE_RST)
    else $error("async clear did not zero registers");

  AST_IN_REG: assert property (
    i_ce |=> st_reg.a == $past(i_a) && st_reg.b == $past(i_b))
    else $error("operand register did not load");

  AST_SIGN_REG: assert property (
    i_ce ##1 (i_cfg.reg_sign && !i_cfg.dual) |->
      sa == $past(i_sign_a) && sb == $past(i_sign_b))
    else $error("registered sign not used");

  AST_WIDE_FULL: assert property (
    (!i_cfg.dual && i_cfg.reg_a == 2'h0 && i_cfg.reg_b == 2'h0
      && !i_cfg.reg_sign && i_cfg.reg_out == 2'h0) |=>
      o_result == $past(mul18(i_a, i_b, i_sign_a, i_sign_b)))
    else $error("wide bypass product wrong");

  AST_UNSIGNED: assert property (
    (!i_cfg.dual && i_cfg.reg_a == 2'h0 && i_cfg.reg_b == 2'h0
      && !i_cfg.reg_sign && i_cfg.reg_out == 2'h0 && !i_sign_a && !i_sign_b)
      |=> o_result == $past(DMHM_RES_W'(i_a) * DMHM_RES_W'(i_b)))
    else $error("unsigned product wrong");

  AST_SIGNED_NEG: assert property (
    (!i_cfg.dual && i_cfg.reg_a == 2'h0 && i_cfg.reg_b == 2'h0
      && !i_cfg.reg_sign && i_cfg.reg_out == 2'h0 && i_sign_a && !i_sign_b
      && i_a == 18'h20000 && i_b == 18'h00001) |=> o_result == 36'hFFFFE0000)
    else $error("signed operand not negative");

  AST_DUAL_HALVES: assert property (
    (i_cfg.dual && i_cfg.reg_a == 2'h0 && i_cfg.reg_b == 2'h0
      && !i_cfg.reg_sign && i_cfg.reg_out == 2'h0) |=>
      o_result[DMHM_HALF_W-1:0] == $past(mul9(i_a[DMHM_SEC_W-1:0],
        i_b[DMHM_SEC_W-1:0], i_sign_a, i_sign_b))
      && o_result[DMHM_RES_W-1:DMHM_HALF_W] ==
        $past(mul9(i_a[DMHM_OP_W-1:DMHM_SEC_W], i_b[DMHM_OP_W-1:DMHM_SEC_W],
        i_sign_a, i_sign_b)))
    else $error("dual halves wrong");

  AST_OUT_REG: assert property (
    i_ce ##1 (i_cfg.reg_out == 2'h3) |=> o_result == $past(st_reg.prod))
    else $error("registered product not delivered");

  // three edges: operand load, product load, then the port flop
  AST_WIDE_PIPE: assert property (
    i_ce ##1 (i_ce && !i_cfg.dual && i_cfg.reg_a == 2'h3
      && i_cfg.reg_b == 2'h3 && i_cfg.reg_sign && i_cfg.reg_out == 2'h3)
      ##1 (i_cfg.reg_out == 2'h3) |=>
      o_result == $past(mul18(i_a, i_b, i_sign_a, i_sign_b), 3))
    else $error("registered wide product wrong");

  AST_OUT_HOLD: assert property (
    (!i_ce && i_cfg.reg_out == 2'h3) ##1 (i_cfg.reg_out == 2'h3)
      |=> $stable(o_result))
    else $error("registered result moved with clock enable low");

  AST_SIGN_LOAD: assert property (
    i_ce |=> st_reg.sign_a == $past(i_sign_a)
      && st_reg.sign_b == $past(i_sign_b))
    else $error("sign register did not load");

  AST_MIXED_SIGN: assert property (
    (!i_cfg.dual && i_cfg.reg_a == 2'h0 && i_cfg.reg_b == 2'h0
      && !i_cfg.reg_sign && i_cfg.reg_out == 2'h0 && !i_sign_a && i_sign_b
      && i_a == 18'h3FFFF && i_b == 18'h3FFFF) |=> o_result == 36'hFFFFC0001)
    else $error("mixed sign product not signed");

  AST_OUT_BYPASS: assert property (
    i_cfg.reg_out == 2'h0 |=> o_result == $past(prod))
    else $error("bypassed result did not follow the multiplier");

  AST_DUAL_SPLIT: assert property (
    i_cfg.dual && i_cfg.reg_a == 2'h1 |->
      op_a[DMHM_OP_W-1:DMHM_SEC_W] == i_a[DMHM_OP_W-1:DMHM_SEC_W]
      && op_a[DMHM_SEC_W-1:0] == st_reg.a[DMHM_SEC_W-1:0])
    else $error("operand sections not split by mode");

  AST_DUAL_OUT_SPLIT: assert property (
    i_cfg.dual && i_cfg.reg_out == 2'h1 |=>
      o_result[DMHM_HALF_W-1:0] == $past(st_reg.prod[DMHM_HALF_W-1:0])
      && o_result[DMHM_RES_W-1:DMHM_HALF_W] ==
        $past(prod[DMHM_RES_W-1:DMHM_HALF_W]))
    else $error("dual result sections not registered apart");

  AST_PROD_LOAD: assert property (
    i_ce |=> st_reg.prod == $past(prod))
    else $error("product register did not load");
endmodule
`default_nettype wire

// *** sim/dmhm_fabric.sv ***
// fabric model that presents operands and signs to the multiplier
`timescale 1ns/1ps
`default_nettype none
module dmhm_fabric
  import dmhm_pkg::*;
(
  input wire logic i_clk,              // block clock
  output logic [DMHM_OP_W-1:0] o_a,    // operand A
  output logic [DMHM_OP_W-1:0] o_b,    // operand B
  output logic o_sign_a,               // A signed
  output logic o_sign_b                // B signed
);
  initial {o_a, o_b, o_sign_a, o_sign_b} = '0;

  // one sign pair only, so both narrow halves share it
  task automatic drive(input logic [DMHM_OP_W-1:0] a, b,
                       input logic sa, sb);
    @(negedge i_clk);
    o_a = a;
    o_b = b;
    {o_sign_a, o_sign_b} = {sa, sb};
  endtask
endmodule
`default_nettype wire

// *** sim/dmhm_mult_tb.sv ***
// self-checking bench for the dual mode hard multiplier
`timescale 1ns/1ps
`default_nettype none
module dmhm_mult_tb;
  import dmhm_pkg::*;
  localparam logic [17:0] A = 18'h3FE01, B = 18'h2C0FF;
  localparam logic [17:0] C = 18'h1F0A3, D = 18'h00E7C;
  logic i_clk = 0, i_resetn = 0, i_ce = 1, i_aclr = 0;
  dmhm_cfg_t i_cfg = '0;
  logic [DMHM_OP_W-1:0] i_a, i_b;
  logic i_sign_a, i_sign_b;
  logic [DMHM_RES_W-1:0] o_result, e, f;
  int failures = 0, compares = 0;
  always #12.5 i_clk = ~i_clk;
  dmhm_fabric dmhm_fabric_i (.i_clk(i_clk), .o_a(i_a), .o_b(i_b),
    .o_sign_a(i_sign_a), .o_sign_b(i_sign_b));
  dmhm_mult dmhm_mult_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_ce(i_ce), .i_aclr(i_aclr), .i_cfg(i_cfg), .i_a(i_a), .i_b(i_b),
    .i_sign_a(i_sign_a), .i_sign_b(i_sign_b), .o_result(o_result));
  // modulo 2^n products keep exact low bits for any sign mix
  function automatic logic [35:0] model(input logic d,
      input logic [17:0] a, b, input logic sa, sb);
    logic [35:0] x, y, p, q;
    x = {{27{sa & a[8]}}, a[8:0]};
    y = {{27{sb & b[8]}}, b[8:0]};
    p = x * y;
    x = {{27{sa & a[17]}}, a[17:9]};
    y = {{27{sb & b[17]}}, b[17:9]};
    q = x * y;
    if (d) return {q[17:0], p[17:0]};
    x = {{18{sa & a[17]}}, a};
    y = {{18{sb & b[17]}}, b};
    return x * y;
  endfunction
  task automatic check(input logic [35:0] exp);
    compares++;
    if (o_result !== exp) begin
      failures++;
      $display("[ERR] o_result exp %h got %h", exp, o_result);
    end
  endtask
  task automatic op(input logic [17:0] a, b, input logic sa, sb);
    dmhm_fabric_i.drive(a, b, sa, sb);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic results;
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_clk);
    failures++;
    results();
  end
  initial begin
    repeat (3) @(negedge i_clk);
    i_resetn = 1;
    repeat (3) @(negedge i_clk);
    for (int m = 0; m < 8; m++) begin
      i_cfg = {m[2], (m[1] ^ m[0]) ? 7'h7F : 7'h00};
      op(A, B, m[1], m[0]);
      check(model(m[2], A, B, m[1], m[0]));
    end
    // only A registered: frozen A, B still flows
    i_cfg = 8'h60;
    op(A, B, 0, 0);
    i_ce = 0;
    op(C, B, 0, 0);
    check(model(0, A, B, 0, 0));
    op(C, D, 0, 0);
    check(model(0, A, D, 0, 0));
    i_ce = 1;
    op(C, D, 0, 0);
    check(model(0, C, D, 0, 0));
    // dual, low A section registered only
    i_cfg = 8'hA0;
    op(A, B, 1, 0);
    i_ce = 0;
    op(C, B, 1, 0);
    e = model(1, C, B, 1, 0);
    f = model(1, A, B, 1, 0);
    check({e[35:18], f[17:0]});
    // sign register frozen keeps old sign
    i_cfg = 8'h04;
    i_ce = 1;
    op(A, B, 1, 0);
    i_ce = 0;
    op(A, B, 0, 0);
    check(model(0, A, B, 1, 0));
    // dual, low product section registered only
    i_cfg = 8'h81;
    i_ce = 1;
    op(A, B, 0, 0);
    i_ce = 0;
    op(C, B, 0, 0);
    e = model(1, C, B, 0, 0);
    f = model(1, A, B, 0, 0);
    check({e[35:18], f[17:0]});
    i_cfg = 8'h7F;
    i_ce = 1;
    op(A, B, 1, 1);
    i_ce = 0;
    i_aclr = 1;
    #1 check('0);
    @(negedge i_clk);
    i_aclr = 0;
    repeat (2) @(negedge i_clk);
    check('0);
    // bypassed paths still flow with enable low: negative and mixed signs
    i_cfg = '0;
    op(18'h20000, 18'h00001, 1, 0);
    check(model(0, 18'h20000, 18'h00001, 1, 0));
    op(18'h3FFFF, 18'h3FFFF, 0, 1);
    check(model(0, 18'h3FFFF, 18'h3FFFF, 0, 1));
    // dual, high B and high result sections registered only
    i_cfg = 8'h92;
    i_ce = 1;
    op(A, B, 0, 1);
    i_ce = 0;
    op(C, D, 0, 1);
    e = model(1, A, B, 0, 1);
    f = model(1, C, D, 0, 1);
    check({e[35:18], f[17:0]});
    results();
  end
endmodule
`default_nettype wire
